// File: uart_irq_pkg.sv
// Constants for the UART interrupt, address-detect and wake-up block.
// Assumes a single 125 MHz clock and an AHB-Lite register port.
package uart_irq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;  // uart_status_reg
  localparam logic [7:0] OFS_CTRL1   = 8'h04;  // uart_control_one
  localparam logic [7:0] OFS_CTRL2   = 8'h08;  // uart_control_two
  localparam logic [7:0] OFS_DATA    = 8'h0C;  // data_buffer_reg
  localparam logic [7:0] OFS_EVENT   = 8'h10;  // event strobe register
  localparam logic [7:0] OFS_PWR     = 8'h14;  // power and system enables
  // uart_control_one fields
  localparam int B_UART_EN    = 7;
  localparam int B_WORD_LEN   = 6;
  localparam int B_PARITY_EN  = 5;
  // uart_control_two fields
  localparam int B_TXEN       = 7;
  localparam int B_RX_EN      = 6;
  localparam int B_ADDR_DET   = 3;
  localparam int B_WAKE       = 2;
  localparam int B_RX_IE      = 1;
  localparam int B_TX_EMPTY_IE= 0;
  localparam int B_TX_IDLE_IE = 4;
  // uart_status_reg fields
  localparam int B_OVERRUN    = 5;
  localparam int B_RX_AVAIL   = 2;
  localparam int B_TX_IDLE    = 1;
  localparam int B_TX_EMPTY   = 0;
  // Event register fields (write 1 to inject datapath events)
  localparam int B_EV_TRIGGER = 0;
  localparam int B_EV_OVERRUN = 1;
  localparam int B_EV_TX_EMPTY= 2;
  localparam int B_EV_TX_IDLE = 3;
  // Power register fields
  localparam int B_CLK_OFF    = 0;
  localparam int B_GIE        = 1;
  localparam int B_URE        = 2;
  localparam int B_STACK_FULL = 3;
  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h03;
  // Wake-up start-up interval
  localparam int STARTUP_NS     = 1024;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STARTUP_LAST = 8'(STARTUP_CYCLES - 1);
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  // Wake sequencer states
  typedef enum logic [1:0] {WK_IDLE, WK_STARTUP, WK_FIRE} wake_state_t;
endpackage

// File: uart_irq_wake.sv
// UART interrupt request, address-detect qualifier and pin wake-up logic.
// Assumes an AHB-Lite master on the same clock and the receive word
// delivered as a one-cycle strobe with a nine-bit word.
// What this block does
// R1 - Seven sources: tx empty, tx idle, fifo trigger, overrun, address, available, pin wake.
// R2 - Enabled condition produces a low-going request pulse, not a level.
// R3 - Vector only with global enable, uart enable and stack not full.
// R4 - Four sources have status flags gated by enables in control two.
// R5 - Each tx source has its own enable; trigger, overrun and available share one.
// R6 - Address detect has no flag; requests while address mode is set.
// R7 - Clock off with enables and wake bit: pin falling edge wakes.
// R8 - Status flags read-only, cleared only by their access sequences.
// R9 - Address mode: available interrupt only when top bit is one.
// R10 - Qualifying bit is ninth bit for long words, eighth otherwise.
// R11 - Without address mode every available event interrupts when the receive interrupt is enabled.
// R12 - Software clears parity enable while address mode is set.
// R13 - Transmitter freezes while the clock is off and resumes.
// R14 - Receiver pauses, not aborts, in idle or sleep.
// R15 - Idle or sleep leaves all registers unchanged.
// R16 - Software finishes transfers before idle or sleep.
// R17 - Pin data during the wake-up interval is ignored.
// R18 - Pin wake interrupts only with global and uart enables; else wake only.
// R19 - Wake interrupt waits until start-up interval has elapsed.
// R20 - Overrun clears on status access followed by data read.
// R21 - Overrun raises the shared receive interrupt when enabled.
// R22 - Request pulse lasts exactly one clock per qualifying event.
`timescale 1ns/1ps
module uart_irq_wake (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_word_valid,
  input  wire logic [8:0]  rx_word,
  input  wire logic        serial_pin,
  output logic             uart_irq_n,
  output logic             vector_req,
  output logic             wake_event,
  output logic             clk_run,
  output logic             rx_accept
);

  logic [7:0]        ctrl1_q;
  logic [7:0]        ctrl2_q;
  logic [7:0]        pwr_q;
  logic [7:0]        data_q;
  logic              overrun_q;
  logic              rx_avail_q;
  logic              tx_empty_q;
  logic              tx_idle_q;
  logic              stat_seen_q;
  logic              pin_q;
  logic [7:0]        startup_q;
  logic              irq_n_q;
  logic              vec_q;
  logic              wake_q;
  uart_irq_pkg::wake_state_t wstate_q;
  logic              ap_valid_q;
  logic              ap_write_q;
  logic [7:0]        ap_addr_q;

  logic clk_off;
  logic rd_stat;
  logic rd_data;
  logic wr_en;
  logic qual_bit;
  logic ev_trig;
  logic ev_ovr;
  logic ev_txe;
  logic ev_txi;
  logic addr_hit;
  logic avail_hit;
  logic src_any;
  logic wake_fire;
  logic pin_fall;

  // Select the word's top bit: ninth for long words, eighth otherwise
  function automatic logic top_bit(input logic [8:0] w, input logic long_word);
    top_bit = long_word ? w[8] : w[7]; // R10
  endfunction

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_ff @(posedge clk) begin
    if (srst) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 8'h00;
    end else if (hready) begin
      ap_valid_q <= hsel && (htrans == uart_irq_pkg::HTRANS_NONSEQ ||
                    htrans == uart_irq_pkg::HTRANS_SEQ);
      ap_write_q <= hwrite;
      ap_addr_q  <= haddr[7:0];
    end
  end

  assign wr_en   = ap_valid_q && ap_write_q;
  assign rd_stat = ap_valid_q && !ap_write_q && ap_addr_q == uart_irq_pkg::OFS_STATUS;
  assign rd_data = ap_valid_q && !ap_write_q && ap_addr_q == uart_irq_pkg::OFS_DATA;
  assign ev_trig = wr_en && ap_addr_q == uart_irq_pkg::OFS_EVENT &&
                   hwdata[uart_irq_pkg::B_EV_TRIGGER];
  assign ev_ovr  = wr_en && ap_addr_q == uart_irq_pkg::OFS_EVENT &&
                   hwdata[uart_irq_pkg::B_EV_OVERRUN];
  assign ev_txe  = wr_en && ap_addr_q == uart_irq_pkg::OFS_EVENT &&
                   hwdata[uart_irq_pkg::B_EV_TX_EMPTY];
  assign ev_txi  = wr_en && ap_addr_q == uart_irq_pkg::OFS_EVENT &&
                   hwdata[uart_irq_pkg::B_EV_TX_IDLE];

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (ap_addr_q)
      uart_irq_pkg::OFS_STATUS: hrdata = {26'h0, overrun_q, 2'h0, rx_avail_q,
                                          tx_idle_q, tx_empty_q};
      uart_irq_pkg::OFS_CTRL1:  hrdata = {24'h0, ctrl1_q};
      uart_irq_pkg::OFS_CTRL2:  hrdata = {24'h0, ctrl2_q};
      uart_irq_pkg::OFS_DATA:   hrdata = {24'h0, data_q};
      uart_irq_pkg::OFS_PWR:    hrdata = {24'h0, pwr_q};
      default:                  hrdata = 32'h0;
    endcase
  end

  // Control registers; clock-off leaves every register untouched
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl1_q <= uart_irq_pkg::CTRL_RST;
      ctrl2_q <= uart_irq_pkg::CTRL_RST;
      pwr_q   <= uart_irq_pkg::CTRL_RST;
    end else if (wr_en) begin // R15
      if (ap_addr_q == uart_irq_pkg::OFS_CTRL1) ctrl1_q <= hwdata[7:0];
      if (ap_addr_q == uart_irq_pkg::OFS_CTRL2) ctrl2_q <= hwdata[7:0];
      if (ap_addr_q == uart_irq_pkg::OFS_PWR)   pwr_q   <= hwdata[7:0];
    end else if (wake_fire) begin
      pwr_q[uart_irq_pkg::B_CLK_OFF] <= 1'b0;
    end
  end

  assign clk_off = pwr_q[uart_irq_pkg::B_CLK_OFF];
  assign clk_run = !clk_off; // R13 R14
  // Received words are dropped while off or still starting up
  assign rx_accept = !clk_off && wstate_q == uart_irq_pkg::WK_IDLE &&
                     ctrl2_q[uart_irq_pkg::B_RX_EN]; // R17

  // Data buffer captures accepted words
  always_ff @(posedge clk) begin
    if (srst) data_q <= 8'h00;
    else if (rx_word_valid && rx_accept) data_q <= rx_word[7:0];
  end

  // Status access arms the clear; a data read completes it
  always_ff @(posedge clk) begin
    if (srst) stat_seen_q <= 1'b0;
    else if (rd_stat) stat_seen_q <= 1'b1;
    else if (rd_data) stat_seen_q <= 1'b0;
  end

  // Status flags: hardware set wins over sequence clear, software never writes
  always_ff @(posedge clk) begin
    if (srst) begin
      overrun_q  <= 1'b0;
      rx_avail_q <= 1'b0;
    end else begin
      if (ev_ovr) overrun_q <= 1'b1;
      else if (rd_data && stat_seen_q) overrun_q <= 1'b0; // R20 R8
      if (rx_word_valid && rx_accept) rx_avail_q <= 1'b1;
      else if (rd_data && stat_seen_q) rx_avail_q <= 1'b0; // R8
    end
  end

  // Transmitter flags; empty and idle set by events, cleared by data write
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_empty_q <= uart_irq_pkg::STATUS_RST[uart_irq_pkg::B_TX_EMPTY];
      tx_idle_q  <= uart_irq_pkg::STATUS_RST[uart_irq_pkg::B_TX_IDLE];
    end else begin
      if (ev_txe) tx_empty_q <= 1'b1;
      else if (wr_en && ap_addr_q == uart_irq_pkg::OFS_DATA) tx_empty_q <= 1'b0;
      if (ev_txi) tx_idle_q <= 1'b1;
      else if (wr_en && ap_addr_q == uart_irq_pkg::OFS_DATA) tx_idle_q <= 1'b0;
    end
  end

  // Source qualification
  assign qual_bit  = top_bit(rx_word, ctrl1_q[uart_irq_pkg::B_WORD_LEN]);
  assign addr_hit  = rx_word_valid && rx_accept &&
                     ctrl2_q[uart_irq_pkg::B_ADDR_DET] && qual_bit; // R6 R9
  assign avail_hit = rx_word_valid && rx_accept &&
                     !ctrl2_q[uart_irq_pkg::B_ADDR_DET] &&
                     ctrl2_q[uart_irq_pkg::B_RX_IE]; // R11
  assign src_any = !clk_off && (
                   (ev_txe && ctrl2_q[uart_irq_pkg::B_TX_EMPTY_IE]) || // R4 R5
                   (ev_txi && ctrl2_q[uart_irq_pkg::B_TX_IDLE_IE]) || // R5
                   ((ev_trig || ev_ovr) && ctrl2_q[uart_irq_pkg::B_RX_IE]) || // R21 R5
                   addr_hit || avail_hit) || wake_fire; // R1

  // Pin edge detector
  always_ff @(posedge clk) begin
    if (srst) pin_q <= 1'b1;
    else pin_q <= serial_pin;
  end
  assign pin_fall = pin_q && !serial_pin;

  // Wake sequencer: edge while off, then wait out start-up
  always_ff @(posedge clk) begin
    if (srst) begin
      wstate_q  <= uart_irq_pkg::WK_IDLE;
      startup_q <= 8'h00;
    end else begin
      unique case (wstate_q)
        uart_irq_pkg::WK_IDLE:
          if (clk_off && pin_fall && ctrl1_q[uart_irq_pkg::B_UART_EN] &&
              ctrl2_q[uart_irq_pkg::B_RX_EN] && ctrl2_q[uart_irq_pkg::B_RX_IE] &&
              ctrl2_q[uart_irq_pkg::B_WAKE]) begin // R7
            wstate_q  <= uart_irq_pkg::WK_STARTUP;
            startup_q <= 8'h00;
          end
        uart_irq_pkg::WK_STARTUP: begin
          startup_q <= startup_q + 8'h01;
          if (startup_q == uart_irq_pkg::STARTUP_LAST)
            wstate_q <= uart_irq_pkg::WK_FIRE; // R19
        end
        uart_irq_pkg::WK_FIRE:
          wstate_q <= uart_irq_pkg::WK_IDLE;
      endcase
    end
  end
  assign wake_fire = wstate_q == uart_irq_pkg::WK_FIRE;

  // Request outputs: one-cycle low pulse, vector gated by system enables
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_n_q <= 1'b1;
      vec_q   <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      irq_n_q <= !(src_any && (!wake_fire || (pwr_q[uart_irq_pkg::B_GIE] &&
                   pwr_q[uart_irq_pkg::B_URE]))); // R2 R22 R18
      vec_q   <= src_any && pwr_q[uart_irq_pkg::B_GIE] && pwr_q[uart_irq_pkg::B_URE] &&
                 !pwr_q[uart_irq_pkg::B_STACK_FULL]; // R3
      wake_q  <= wake_fire; // R18
    end
  end
  assign uart_irq_n = irq_n_q;
  assign vector_req = vec_q;
  assign wake_event = wake_q;

  // Assertions
  sequence s_wake_arm;
    wstate_q == uart_irq_pkg::WK_IDLE ##1 wstate_q == uart_irq_pkg::WK_STARTUP;
  endsequence
  chk_pulse_one_cycle: assert property (@(posedge clk) disable iff (srst)
    !uart_irq_n |=> uart_irq_n || $past(src_any)) // R22
    else $error("request low without a source");
  chk_pulse_follows: assert property (@(posedge clk) disable iff (srst)
    (src_any && !wake_fire) |=> !uart_irq_n) // R2
    else $error("source did not pulse request");
  chk_vector_gate: assert property (@(posedge clk) disable iff (srst)
    vector_req |-> $past(pwr_q[uart_irq_pkg::B_GIE]) && !$past(pwr_q[uart_irq_pkg::B_STACK_FULL]))
    else $error("vector without enables"); // R3
  chk_addr_zero: assert property (@(posedge clk) disable iff (srst)
    (rx_word_valid && rx_accept && ctrl2_q[uart_irq_pkg::B_ADDR_DET] && !qual_bit &&
     !ev_trig && !ev_ovr && !ev_txe && !ev_txi && !wake_fire) |=> uart_irq_n)
    else $error("non-address word interrupted"); // R9
  chk_wake_delay: assert property (@(posedge clk) disable iff (srst)
    s_wake_arm |-> ##[1:200] wake_fire) // R19
    else $error("wake not issued after start-up");
  chk_wake_not_early: assert property (@(posedge clk) disable iff (srst)
    s_wake_arm |-> !wake_fire [*8]) // R19
    else $error("wake issued too early");
  chk_rx_ignored: assert property (@(posedge clk) disable iff (srst)
    (wstate_q != uart_irq_pkg::WK_IDLE) |-> !rx_accept) // R17
    else $error("rx accepted during wake-up");
  chk_overrun_clear: assert property (@(posedge clk) disable iff (srst)
    ($fell(overrun_q)) |-> $past(rd_data) && $past(stat_seen_q)) // R20
    else $error("overrun cleared without sequence");

  // Overrun flag only rises on its hardware event, never by software
  chk_overrun_set: assert property (@(posedge clk) disable iff (srst)
    $rose(overrun_q) |-> $past(ev_ovr)) // R8
    else $error("overrun flag set without event");
  // Available flag only rises on an accepted received word
  chk_avail_set: assert property (@(posedge clk) disable iff (srst)
    $rose(rx_avail_q) |-> $past(rx_word_valid && rx_accept)) // R8
    else $error("available flag set without word");
  // Enabled transmit-empty event pulses the request
  chk_tx_empty_req: assert property (@(posedge clk) disable iff (srst)
    (ev_txe && !clk_off && ctrl2_q[uart_irq_pkg::B_TX_EMPTY_IE]) |=> !uart_irq_n) // R4
    else $error("tx empty did not request");
  // Enabled transmit-idle event pulses the request
  chk_tx_idle_req: assert property (@(posedge clk) disable iff (srst)
    (ev_txi && !clk_off && ctrl2_q[uart_irq_pkg::B_TX_IDLE_IE]) |=> !uart_irq_n) // R5
    else $error("tx idle did not request");
  // Trigger and overrun share the receive enable
  chk_rx_shared_req: assert property (@(posedge clk) disable iff (srst)
    ((ev_trig || ev_ovr) && !clk_off && ctrl2_q[uart_irq_pkg::B_RX_IE]) |=> !uart_irq_n) // R21
    else $error("receive source did not request");
  // Detected address always requests
  chk_addr_req: assert property (@(posedge clk) disable iff (srst)
    addr_hit |=> !uart_irq_n) // R6
    else $error("address did not request");
  // Without address mode every available word requests when the receive interrupt is enabled
  chk_avail_req: assert property (@(posedge clk) disable iff (srst)
    avail_hit |=> !uart_irq_n) // R11
    else $error("available word did not request");
  // Qualifying bit follows the word-length select
  chk_qual_select: assert property (@(posedge clk) disable iff (srst)
    rx_word_valid |-> qual_bit == rx_word[ctrl1_q[uart_irq_pkg::B_WORD_LEN] ? 8 : 7]) // R10
    else $error("wrong qualifying bit");
  // Clock off silences every source but the pin wake
  chk_off_silent: assert property (@(posedge clk) disable iff (srst)
    (clk_off && !wake_fire) |=> uart_irq_n) // R13
    else $error("request while clock off");
  // Receiver takes nothing while the clock is off
  chk_rx_off: assert property (@(posedge clk) disable iff (srst)
    clk_off |-> !rx_accept) // R14
    else $error("rx accepted while clock off");
  // Wake without system enables gives an event only
  chk_wake_only: assert property (@(posedge clk) disable iff (srst)
    (wake_fire && !(pwr_q[uart_irq_pkg::B_GIE] && pwr_q[uart_irq_pkg::B_URE]))
    |=> uart_irq_n && wake_event) // R18
    else $error("wake without enables requested");
  // Wake with system enables requests and signals the event
  chk_wake_irq: assert property (@(posedge clk) disable iff (srst)
    (wake_fire && pwr_q[uart_irq_pkg::B_GIE] && pwr_q[uart_irq_pkg::B_URE])
    |=> !uart_irq_n && wake_event) // R7
    else $error("wake did not request");
  // Completed wake restarts the clock
  chk_wake_clock: assert property (@(posedge clk) disable iff (srst)
    (wake_fire && !wr_en) |=> !clk_off) // R7
    else $error("clock not restored after wake");
  // Controls only change on a bus write, never on power-down
  chk_ctrl_hold: assert property (@(posedge clk) disable iff (srst)
    !wr_en |=> $stable(ctrl1_q) && $stable(ctrl2_q)) // R15
    else $error("control changed without write");
  // A vector always comes with a request pulse
  chk_vec_with_req: assert property (@(posedge clk) disable iff (srst)
    vector_req |-> !uart_irq_n) // R3
    else $error("vector without request pulse");
endmodule

// File: serial_node.sv
// Model of the remote serial node: drives the shared pin and received words.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module serial_node (
  input  wire logic       clk,
  output logic            serial_pin,
  output logic            rx_word_valid,
  output logic [8:0]      rx_word
);
  // Pin idles high, as on a pulled-up shared line
  initial begin
    serial_pin    = 1'b1;
    rx_word_valid = 1'b0;
    rx_word       = 9'h0AA;
  end

  // One word for one cycle, then the released bus shows the inverse
  task automatic send(input logic [8:0] w);
    rx_word_valid <= 1'b1;
    rx_word       <= w;
    @(posedge clk);
    rx_word_valid <= 1'b0;
    rx_word       <= ~w;
  endtask

  // Start-bit style low on the pin, then back to idle
  task automatic fall;
    serial_pin <= 1'b0;
    repeat (8) @(posedge clk);
    serial_pin <= 1'b1;
  endtask
endmodule

// File: uart_interrupt_wake_logic_bench.sv
// Self-checking bench for the UART interrupt, address-detect and wake block.
// Assumes the serial node model and a zero-wait AHB-Lite register port.
`timescale 1ns/1ps
module uart_interrupt_wake_logic_bench;
  logic        clk, srst, hsel, hwrite, hreadyout, hresp, serial_pin, rx_word_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  rx_word;
  logic        uart_irq_n, vector_req, wake_event, clk_run, rx_accept;
  int          n_fail, num_checks, n_irq, n_vec, n_wake, b_i, b_v, b_w;
  logic [8:0]  aw [4] = '{9'h100, 9'h0FF, 9'h080, 9'h07F};

  function automatic logic [31:0] m(input int b);
    return 32'h1 << b;
  endfunction
  localparam logic [31:0] GU  = m(uart_irq_pkg::B_GIE) | m(uart_irq_pkg::B_URE);
  localparam logic [31:0] OVR = m(uart_irq_pkg::B_OVERRUN);
  localparam logic [31:0] UEN = m(uart_irq_pkg::B_UART_EN);
  localparam logic [31:0] RXE = m(uart_irq_pkg::B_RX_EN);
  localparam logic [31:0] RECEIVE_INT_ENABLE = m(uart_irq_pkg::B_RX_IE);
  localparam logic [31:0] WK  = RXE | RECEIVE_INT_ENABLE | m(uart_irq_pkg::B_WAKE);
  localparam logic [31:0] OFF = m(uart_irq_pkg::B_CLK_OFF);

  uart_irq_wake DUT (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word), .serial_pin(serial_pin),
    .uart_irq_n(uart_irq_n), .vector_req(vector_req), .wake_event(wake_event),
    .clk_run(clk_run), .rx_accept(rx_accept)
  );
  serial_node node (.clk(clk), .serial_pin(serial_pin), .rx_word_valid(rx_word_valid),
                    .rx_word(rx_word));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts low request cycles and output pulses
  always @(posedge clk) begin
    if (uart_irq_n === 1'b0) n_irq <= n_irq + 1;
    if (vector_req === 1'b1) n_vec <= n_vec + 1;
    if (wake_event === 1'b1) n_wake <= n_wake + 1;
  end

  // Single AHB-Lite transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= uart_irq_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmpv(rd & msk, exp);
    cmpv({31'h0, hresp}, 32'h0);
  endtask

  task automatic mark;
    b_i = n_irq;
    b_v = n_vec;
    b_w = n_wake;
  endtask

  // Pulse counts since the last mark: request, vector, wake
  task automatic chk_cnt(input int ei, input int ev, input int ew);
    repeat (4) @(posedge clk);
    num_checks++;
    if (n_irq - b_i != ei || n_vec - b_v != ev || n_wake - b_w != ew) begin
      n_fail++;
      $display("[FAIL] %0t got %0h %0h %0h exp %0h %0h %0h", $time, n_irq - b_i,
               n_vec - b_v, n_wake - b_w, ei, ev, ew);
    end
    mark;
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    end_of_test;
  end

  // Main sequence
  initial begin
    {srst, hsize} = {1'b1, 3'h2};
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {n_fail, num_checks, n_irq, n_vec, n_wake} = '0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc(uart_irq_pkg::OFS_STATUS, 32'hFF, 32'(uart_irq_pkg::STATUS_RST));
    bus(1'b1, uart_irq_pkg::OFS_STATUS, 32'hFF);
    rdc(uart_irq_pkg::OFS_STATUS, 32'hFF, 32'(uart_irq_pkg::STATUS_RST));
    rdc(uart_irq_pkg::OFS_CTRL2, 32'hFF, 32'(uart_irq_pkg::CTRL_RST));
    rdc(8'h18, 32'hFFFF_FFFF, 32'h0);
    // Source masking: each transmitter source has its own enable
    bus(1'b1, uart_irq_pkg::OFS_PWR, GU);
    bus(1'b1, uart_irq_pkg::OFS_CTRL2, m(uart_irq_pkg::B_TX_EMPTY_IE));
    mark;
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_TX_IDLE));
    chk_cnt(0, 0, 0);
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_TX_EMPTY));
    chk_cnt(1, 1, 0);
    bus(1'b1, uart_irq_pkg::OFS_CTRL2, m(uart_irq_pkg::B_TX_IDLE_IE));
    mark;
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_TX_IDLE));
    chk_cnt(1, 1, 0);
    // Receive sources share one enable
    bus(1'b1, uart_irq_pkg::OFS_CTRL2, RECEIVE_INT_ENABLE);
    mark;
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_TX_EMPTY));
    chk_cnt(0, 0, 0);
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_TRIGGER));
    chk_cnt(1, 1, 0);
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_OVERRUN));
    chk_cnt(1, 1, 0);
    rdc(uart_irq_pkg::OFS_STATUS, OVR, OVR);
    rdc(uart_irq_pkg::OFS_STATUS, OVR, OVR);
    rdc(uart_irq_pkg::OFS_DATA, 32'hFF, 32'h0);
    rdc(uart_irq_pkg::OFS_STATUS, OVR, 32'h0);
    // Vectoring needs both enables and room on the stack
    bus(1'b1, uart_irq_pkg::OFS_PWR, GU | m(uart_irq_pkg::B_STACK_FULL));
    mark;
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_TRIGGER));
    chk_cnt(1, 0, 0);
    bus(1'b1, uart_irq_pkg::OFS_PWR, m(uart_irq_pkg::B_URE));
    mark;
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_TRIGGER));
    chk_cnt(1, 0, 0);
    // Address mode with parity kept clear: long words then short words
    bus(1'b1, uart_irq_pkg::OFS_PWR, GU);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, uart_irq_pkg::OFS_CTRL1, UEN | (i < 2 ? m(uart_irq_pkg::B_WORD_LEN) : 0));
      bus(1'b1, uart_irq_pkg::OFS_CTRL2, RXE | m(uart_irq_pkg::B_ADDR_DET));
      mark;
      node.send(aw[i]);
      chk_cnt(i % 2 == 0, i % 2 == 0, 0);
    end
    rdc(uart_irq_pkg::OFS_STATUS, m(uart_irq_pkg::B_RX_AVAIL), m(uart_irq_pkg::B_RX_AVAIL));
    rdc(uart_irq_pkg::OFS_DATA, 32'hFF, 32'h7F);
    bus(1'b1, uart_irq_pkg::OFS_CTRL2, RXE | RECEIVE_INT_ENABLE);
    mark;
    node.send(9'h000);
    chk_cnt(1, 1, 0);
    // Pin wake with interrupts enabled; transfers finished beforehand
    bus(1'b1, uart_irq_pkg::OFS_CTRL2, WK);
    bus(1'b1, uart_irq_pkg::OFS_PWR, OFF | GU);
    mark;
    @(posedge clk);
    cmpv({31'h0, clk_run}, 32'h0);
    bus(1'b1, uart_irq_pkg::OFS_EVENT, m(uart_irq_pkg::B_EV_TRIGGER));
    chk_cnt(0, 0, 0);
    node.fall;
    cmpv({31'h0, rx_accept}, 32'h0);
    node.send(9'h100);
    chk_cnt(0, 0, 0);
    repeat (95) @(posedge clk);
    chk_cnt(0, 0, 0);
    repeat (30) @(posedge clk);
    chk_cnt(1, 1, 1);
    cmpv({31'h0, clk_run}, 32'h1);
    rdc(uart_irq_pkg::OFS_CTRL2, 32'hFF, WK);
    // Pin wake without global enable gives a wake event only
    bus(1'b1, uart_irq_pkg::OFS_PWR, OFF);
    mark;
    node.fall;
    repeat (140) @(posedge clk);
    chk_cnt(0, 0, 1);
    end_of_test;
  end
endmodule
